// ---- design/qdrsc_pkg.sv ----
package qdrsc_pkg;

	// ----------------------------------------
	// Channels, clock and timing
	// ----------------------------------------
	localparam int          NCH          = 4;
	localparam int          CODE_BITS    = 12;
	localparam int          CLK_NS       = 20;
	localparam int          CLK_MHZ      = 1000 / CLK_NS;
	localparam int          CAL_TIME_US  = 200;
	localparam int          CAL_CYCLES   = CAL_TIME_US * CLK_MHZ;
	localparam int          SPIKE_NS     = 50;
	localparam int          FILT_LEN     = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0]  BYTE_BITS    = 4'h8;

	// ----------------------------------------
	// Bus addresses
	// ----------------------------------------
	localparam logic [4:0]  ADDR_UPPER   = 5'h03;
	localparam logic [6:0]  BCAST_ADDR   = 7'h08;

	// ----------------------------------------
	// Command byte: opcode in [7:4], channel in [3:0]
	// ----------------------------------------
	localparam logic [3:0]  OP_CODE      = 4'h0;
	localparam logic [3:0]  OP_LOAD      = 4'h1;
	localparam logic [3:0]  OP_CODE_LOAD = 4'h2;
	localparam logic [3:0]  OP_REF       = 4'h3;
	localparam logic [3:0]  OP_POWER     = 4'h4;
	localparam logic [3:0]  OP_CLEAR     = 4'h5;
	localparam logic [3:0]  OP_RESET     = 4'h6;
	localparam int          ALL_CH_BIT   = 3;

	// ----------------------------------------
	// Reference selection and reset values
	// ----------------------------------------
	localparam logic [1:0]  REF_EXT      = 2'h0;
	localparam logic [1:0]  REF_2V048    = 2'h1;
	localparam logic [1:0]  REF_2V500    = 2'h2;
	localparam logic [1:0]  REF_4V096    = 2'h3;
	localparam logic [1:0]  RST_REF      = REF_EXT;
	localparam logic [3:0]  RST_PD       = 4'h0;

	// ----------------------------------------
	// Serial engine states
	// ----------------------------------------
	typedef enum logic [2:0]
	{
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_WR   = 3'b010,
		S_ACK  = 3'b011,
		S_RD   = 3'b100,
		S_MACK = 3'b101
	} qdrsc_fsm_e;

endpackage

// ---- design/qdrsc_ctrl.sv ----
`timescale 1ns/1ps
// Contract
// R1 - Four channels, each an unsigned 12-bit code, zero meaning zero output.
// R2 - Serial input shifts in, then routes to control, one or all channels.
// R3 - Pending register stores a setting without touching the output.
// R4 - Pending register written by pending-write and write-and-update commands.
// R5 - Output register holds the value applied to the channel output.
// R6 - Write-and-update writes output and pending registers together.
// R7 - Transfer copies pending into output for each addressed channel.
// R8 - Both registers keep their contents while channels are powered down.
// R9 - Pending-write and transfer still act while powered down.
// R10 - Soft clear and soft reset zero every pending and output register.
// R11 - Power-on clears all channel outputs to code zero.
// R12 - Software selects internal reference 2.048V, 2.500V or 4.096V.
// R13 - After reset the reference is external mode.
// R14 - Master makes the serial clock, starts transfers, at most 400kHz.
// R15 - Write is slave address, command byte, then data word.
// R16 - Each sequence opens with START or repeated START, closes with STOP.
// R17 - Every byte to the device is 8 bits plus one acknowledge pulse.
// R18 - For reads master sends address, then nine clocks per byte.
// R19 - Device drives read data bits in step with master clocks.
// R20 - Master acknowledges each read byte, ends with not-acknowledge and STOP.
// R21 - Data line is input and open-drain output; clock is input only.
// R22 - Address is 00011 plus two bits from the address strap.
// R23 - Broadcast byte 00010000 acknowledged regardless of strap, writes only.
// R24 - Data bytes held temporarily, moved to target during acknowledge.
// R25 - About 200us calibration after power-up; commands then are ignored.
// R26 - Clock and data lines synchronised and filtered before edge detection.
module qdrsc_ctrl
#(
	parameter int DW         = qdrsc_pkg::CODE_BITS,
	parameter int CAL_CYCLES = qdrsc_pkg::CAL_CYCLES
)
(
	// Clock and reset
	input  wire logic                           core_clk,
	input  wire logic                           rst,
	// Serial bus pins
	input  wire logic                           scl_in,
	input  wire logic                           sda_in,
	output logic                                sda_out,
	output logic                                sda_oe_n,
	// Address strap
	input  wire logic [1:0]                     addr_sel,
	// Converter side
	output logic [qdrsc_pkg::NCH*DW-1:0]        chan_code,
	output logic [qdrsc_pkg::NCH-1:0]           chan_pd,
	output logic [1:0]                          ref_sel,
	output logic                                cal_busy
);

	localparam int NCH = qdrsc_pkg::NCH;
	localparam int FL  = qdrsc_pkg::FILT_LEN;
	localparam int CW  = $clog2(CAL_CYCLES + 1);

	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	// Readback packs the code left-justified into two bytes.
	if (DW < 8 || DW > 16)
	begin : g_dw_chk
		$error("DW must lie between 8 and 16");
	end
	if (CAL_CYCLES < 1)
	begin : g_cal_chk
		$error("CAL_CYCLES must be at least 1");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed
	{
		logic [1:0]                   scl_s;
		logic [1:0]                   sda_s;
		logic [1:0]                   adr_m;
		logic [1:0]                   adr_q;
		logic [FL-1:0]                scl_h;
		logic [FL-1:0]                sda_h;
		logic                         scl_f;
		logic                         sda_f;
		qdrsc_pkg::qdrsc_fsm_e        st;
		logic [3:0]                   cnt;
		logic [7:0]                   sh;
		logic [7:0]                   tx;
		logic                         rw;
		logic [1:0]                   bidx;
		logic [1:0]                   ridx;
		logic [7:0]                   cmd;
		logic [7:0]                   dhi;
		logic                         macked;
		logic                         oe_n;
		logic [NCH-1:0][DW-1:0]       pend;
		logic [NCH-1:0][DW-1:0]       dac;
		logic [1:0]                   refs;
		logic [NCH-1:0]               pd;
		logic [CW-1:0]                cal;
		logic                         busy;
	} qdrsc_regs_s;

	qdrsc_regs_s     r;
	qdrsc_regs_s     n;
	logic            rise_c;
	logic            fall_c;
	logic            start_c;
	logic            stop_c;
	logic            match_c;
	logic            exec_c;
	logic [15:0]     word_c;
	logic [DW-1:0]   code_c;
	logic [NCH-1:0]  mask_c;

	// ----------------------------------------
	// Decoders
	// ----------------------------------------
	// Channel field: bit 3 selects all channels, else the low bits pick one.
	function automatic logic [NCH-1:0] chan_mask(input logic [3:0] sel);
		logic [NCH-1:0] m;
		m = '0;
		if (sel[qdrsc_pkg::ALL_CH_BIT])
			m = '1;
		else
			m[sel[1:0]] = 1'b1;
		return m;
	endfunction

	// Readback: output register of the addressed channel, then all ones.
	function automatic logic [7:0] rd_byte(input logic [DW-1:0] v, input logic [1:0] idx);
		logic [15:0] w;
		w = 16'(v) << (16 - DW);
		if (idx == 2'h0)
			return w[15:8];
		else if (idx == 2'h1)
			return w[7:0];
		else
			return 8'hFF;
	endfunction

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	// Every field is computed here; the clocked process only stores it.
	always_comb
	begin
		n = r;
		// Two flops per pin; only the second stage feeds the filter.
		n.scl_s = {r.scl_s[0], scl_in};                         // see R26
		n.sda_s = {r.sda_s[0], sda_in};                         // see R26
		n.adr_m = addr_sel;
		n.adr_q = r.adr_m;
		n.scl_h = {r.scl_h[FL-2:0], r.scl_s[1]};
		n.sda_h = {r.sda_h[FL-2:0], r.sda_s[1]};
		// A level must hold for the whole window, which rejects short spikes.
		if (&r.scl_h)
			n.scl_f = 1'b1;                                     // see R26
		else if (~|r.scl_h)
			n.scl_f = 1'b0;
		if (&r.sda_h)
			n.sda_f = 1'b1;
		else if (~|r.sda_h)
			n.sda_f = 1'b0;
		rise_c  = n.scl_f & ~r.scl_f;
		fall_c  = ~n.scl_f & r.scl_f;
		start_c = r.scl_f & n.scl_f & r.sda_f & ~n.sda_f;       // see R16
		stop_c  = r.scl_f & n.scl_f & ~r.sda_f & n.sda_f;       // see R16
		// Calibration timer runs down once after reset.
		if (r.cal != '0)
			n.cal = r.cal - CW'(1);                             // see R25
		n.busy = (n.cal != '0);
		// Own address or write-only broadcast.
		match_c = ((r.sh[7:3] == qdrsc_pkg::ADDR_UPPER)
			&& (r.sh[2:1] == r.adr_q))                          // see R22
			|| ((r.sh[7:1] == qdrsc_pkg::BCAST_ADDR) && !r.sh[0]); // see R23
		word_c = {r.dhi, r.sh};
		code_c = word_c[15 -: DW];
		mask_c = chan_mask(r.cmd[3:0]);
		exec_c = 1'b0;

		if (start_c)
		begin
			n.st   = qdrsc_pkg::S_ADDR;
			n.cnt  = '0;
			n.bidx = '0;
			n.oe_n = 1'b1;
		end
		else if (stop_c)
		begin
			// An unfinished command is dropped with no effect.
			n.st   = qdrsc_pkg::S_IDLE;
			n.oe_n = 1'b1;
		end
		else
		begin
			// Data is taken on the rising clock edge.
			if (rise_c && (r.st == qdrsc_pkg::S_ADDR || r.st == qdrsc_pkg::S_WR))
			begin
				n.sh  = {r.sh[6:0], r.sda_f};                   // see R2
				n.cnt = r.cnt + 4'h1;
			end
			if (rise_c && r.st == qdrsc_pkg::S_RD)
				n.cnt = r.cnt + 4'h1;
			if (rise_c && r.st == qdrsc_pkg::S_MACK)
				n.macked = ~r.sda_f;                            // see R20
			// The data line only changes while the clock is low.
			if (fall_c)
			begin
				case (r.st)
					qdrsc_pkg::S_ADDR:
					begin
						if (r.cnt == qdrsc_pkg::BYTE_BITS)
						begin
							if (match_c)
							begin
								n.st   = qdrsc_pkg::S_ACK;
								n.oe_n = 1'b0;                  // see R17
								n.rw   = r.sh[0];
							end
							else
								n.st = qdrsc_pkg::S_IDLE;
						end
					end
					qdrsc_pkg::S_WR:
					begin
						if (r.cnt == qdrsc_pkg::BYTE_BITS)
						begin
							n.st   = qdrsc_pkg::S_ACK;
							n.oe_n = 1'b0;                      // see R17
							// Bytes move to their target in the ack slot.
							case (r.bidx)
								2'h0:
								begin
									n.cmd  = r.sh;              // see R24
									n.ridx = '0;
									n.bidx = 2'h1;
								end
								2'h1:
								begin
									n.dhi  = r.sh;              // see R24
									n.bidx = 2'h2;
								end
								default:
								begin
									exec_c = 1'b1;              // see R24
									n.bidx = 2'h0;
								end
							endcase
						end
					end
					qdrsc_pkg::S_ACK:
					begin
						n.cnt = '0;
						if (r.rw)
						begin
							n.st   = qdrsc_pkg::S_RD;
							n.tx   = rd_byte(r.dac[r.cmd[1:0]], r.ridx);
							n.oe_n = n.tx[7];                   // see R19
							n.ridx = r.ridx + 2'(r.ridx != 2'h2);
						end
						else
						begin
							n.st   = qdrsc_pkg::S_WR;
							n.oe_n = 1'b1;
						end
					end
					qdrsc_pkg::S_RD:
					begin
						if (r.cnt == qdrsc_pkg::BYTE_BITS)
						begin
							n.st   = qdrsc_pkg::S_MACK;
							n.oe_n = 1'b1;
						end
						else
						begin
							n.tx   = {r.tx[6:0], 1'b1};
							n.oe_n = r.tx[6];                   // see R19
						end
					end
					qdrsc_pkg::S_MACK:
					begin
						// A not-acknowledge returns the engine to idle until the next START.
						n.cnt = '0;
						if (r.macked)
						begin
							n.st   = qdrsc_pkg::S_RD;
							n.tx   = rd_byte(r.dac[r.cmd[1:0]], r.ridx);
							n.oe_n = n.tx[7];                   // see R19
							n.ridx = r.ridx + 2'(r.ridx != 2'h2);
						end
						else
							n.st = qdrsc_pkg::S_IDLE;
					end
					default:
						n.st = qdrsc_pkg::S_IDLE;
				endcase
			end
		end

		// Command execution; power-down never blocks register updates.
		if (exec_c && r.cal == '0)                              // see R25
		begin
			case (r.cmd[7:4])
				qdrsc_pkg::OP_CODE:
				begin
					for (int i = 0; i < NCH; i++)
						if (mask_c[i])
							n.pend[i] = code_c;                 // see R3, see R4, see R9
				end
				qdrsc_pkg::OP_LOAD:
				begin
					for (int i = 0; i < NCH; i++)
						if (mask_c[i])
							n.dac[i] = r.pend[i];               // see R7, see R9
				end
				qdrsc_pkg::OP_CODE_LOAD:
				begin
					for (int i = 0; i < NCH; i++)
						if (mask_c[i])
						begin
							n.pend[i] = code_c;                 // see R4
							n.dac[i]  = code_c;                 // see R6
						end
				end
				qdrsc_pkg::OP_REF:
					n.refs = word_c[1:0];                       // see R12
				qdrsc_pkg::OP_POWER:
					n.pd = word_c[NCH-1:0];                     // see R8
				qdrsc_pkg::OP_CLEAR:
				begin
					n.pend = '0;                                // see R10
					n.dac  = '0;
				end
				qdrsc_pkg::OP_RESET:
				begin
					n.pend = '0;                                // see R10
					n.dac  = '0;
					n.refs = qdrsc_pkg::RST_REF;
					n.pd   = qdrsc_pkg::RST_PD;
				end
				default:
					n.st = r.st;
			endcase
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// Reset doubles as power-on: zero codes, external reference, recalibrate.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			r        <= '0;                                     // see R11
			r.scl_s  <= '1;
			r.sda_s  <= '1;
			r.scl_h  <= '1;
			r.sda_h  <= '1;
			r.scl_f  <= 1'b1;
			r.sda_f  <= 1'b1;
			r.oe_n   <= 1'b1;
			r.st     <= qdrsc_pkg::S_IDLE;
			r.refs   <= qdrsc_pkg::RST_REF;                     // see R13
			r.pd     <= qdrsc_pkg::RST_PD;
			r.cal    <= CW'(CAL_CYCLES);                        // see R25
			r.busy   <= 1'b1;
		end
		else
			r <= n;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Open drain: the pin only ever pulls low; the clock is never driven.
	assign sda_out   = 1'b0;                                    // see R21
	assign sda_oe_n  = r.oe_n;                                  // see R21
	assign chan_code = r.dac;                                   // see R1, see R5
	assign chan_pd   = r.pd;
	assign ref_sel   = r.refs;
	assign cal_busy  = r.busy;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_run(logic [3:0] op);
		exec_c && r.cal == '0 && r.cmd[7:4] == op;
	endsequence

	a_reset_codes: assert property ($fell(rst) |-> r.dac == '0 && r.pend == '0) // see R11
		else $error("codes not zero after reset");
	a_reset_ref: assert property ($fell(rst) |-> ref_sel == qdrsc_pkg::REF_EXT) // see R13
		else $error("reference not external after reset");
	a_pend_only: assert property (s_run(qdrsc_pkg::OP_CODE) |=> chan_code == $past(chan_code)) // see R3
		else $error("pending write changed the output");
	a_load_copy: assert property (s_run(qdrsc_pkg::OP_LOAD) && mask_c[0] |=> r.dac[0] == $past(r.pend[0])) // see R7
		else $error("transfer did not copy pending value");
	a_write_upd: assert property (s_run(qdrsc_pkg::OP_CODE_LOAD) && mask_c[0] |=> r.dac[0] == r.pend[0]) // see R6
		else $error("write-and-update left registers unequal");
	a_clear_all: assert property ((s_run(qdrsc_pkg::OP_CLEAR) or s_run(qdrsc_pkg::OP_RESET))
		|=> r.dac == '0 && r.pend == '0) // see R10
		else $error("clear left a register nonzero");
	a_cal_block: assert property (exec_c && cal_busy |=> r.pend == $past(r.pend) && r.dac == $past(r.dac)) // see R25
		else $error("command acted on during calibration");
	a_ack_drive: assert property (r.st == qdrsc_pkg::S_ACK |-> !sda_oe_n) // see R17
		else $error("data line released during acknowledge");
	a_stop_free: assert property (stop_c |=> sda_oe_n && r.st == qdrsc_pkg::S_IDLE) // see R16
		else $error("line held after STOP");
	a_bcast_read: assert property (r.st == qdrsc_pkg::S_ADDR && fall_c && r.cnt == 4'h8
		&& r.sh == {qdrsc_pkg::BCAST_ADDR, 1'b1} && r.sh[7:3] != qdrsc_pkg::ADDR_UPPER
		|=> sda_oe_n ##1 r.st != qdrsc_pkg::S_RD) // see R23
		else $error("broadcast read was acknowledged");
	a_read_bit: assert property (r.st == qdrsc_pkg::S_RD |-> sda_oe_n == r.tx[7]) // see R19
		else $error("read bit differs from shift register");

endmodule

// ---- dv/qdrsc_bus_master.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Serial bus master model
// ----------------------------------------
module qdrsc_bus_master
(
	// Clock
	input  wire logic core_clk,
	// Device pull on the data wire
	input  wire logic dev_low,
	// Bus lines
	output logic      scl,
	output logic      sda
);
	logic drv_low;
	int   ql;

	// Open drain with pull-up, so a released line reads high.
	assign sda = ~(drv_low | dev_low);

	// The clock stands high and the data wire is released at idle.
	initial
	begin
		scl = 1'b1;
		drv_low = 1'b0;
		ql = 32;
	end

	// A quarter bus period of 32 cycles; a 128-cycle period keeps the bus below 400kHz.
	task automatic q();
		repeat (ql) @(negedge core_clk);
	endtask

	// START or repeated START, leaving the clock low.
	task automatic start();
		q();
		drv_low = 1'b0;
		q();
		scl = 1'b1;
		q();
		drv_low = 1'b1;
		q();
		scl = 1'b0;
	endtask

	// STOP, leaving both lines released.
	task automatic stop();
		q();
		drv_low = 1'b1;
		q();
		scl = 1'b1;
		q();
		drv_low = 1'b0;
		q();
	endtask

	// One clock: data is set mid-low and sampled mid-high.
	task automatic xfer(input logic b, output logic r);
		q();
		drv_low = ~b;
		q();
		scl = 1'b1;
		q();
		r = sda;
		q();
		scl = 1'b0;
	endtask

	// Eight bits out, then the acknowledge clock.
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			xfer(d[i], r);
		xfer(1'b1, r);
		ack = ~r;
	endtask

	// Nine clocks per byte read; the ninth carries our answer.
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			xfer(1'b1, r);
			d[i] = r;
		end
		xfer(nack, r);
	endtask
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
	localparam int         CAL   = 6000;
	localparam int         LIMIT = 106000;
	localparam logic [6:0] ADR   = {qdrsc_pkg::ADDR_UPPER, 2'h2};
	localparam logic [6:0] ADR1  = {qdrsc_pkg::ADDR_UPPER, 2'h1};
	logic        core_clk;
	logic        rst;
	logic        scl_line;
	logic        sda_line;
	logic        sda_out;
	logic        sda_oe_n;
	logic        cal_busy;
	logic [1:0]  addr_sel;
	logic [1:0]  ref_sel;
	logic [3:0]  chan_pd;
	logic [47:0] chan_code;
	int          fails;
	int          checks_done;
	int          cyc;

	// ----------------------------------------
	// Clock, design and bus master
	// ----------------------------------------
	initial
	begin
		core_clk = 1'b0;
		rst = 1'b1;
		addr_sel = 2'h2;
		fails = 0;
		checks_done = 0;
		cyc = 0;
	end
	always #10 core_clk = ~core_clk;

	qdrsc_ctrl #(.CAL_CYCLES(CAL)) u_dut (.core_clk(core_clk), .rst(rst), .scl_in(scl_line),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel(addr_sel),
		.chan_code(chan_code), .chan_pd(chan_pd), .ref_sel(ref_sel), .cal_busy(cal_busy));
	qdrsc_bus_master u_m (.core_clk(core_clk), .dev_low(~sda_oe_n & ~sda_out), .scl(scl_line),
		.sda(sda_line));

	// A hung handshake must still end the run with a verdict.
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			fails++;
			test_done();
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic test_done();
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One full write: address, command, data high then low.
	task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] w, input logic ok);
		logic       k;
		logic [2:0] ks;
		u_m.start();
		u_m.wbyte({a, 1'b0}, k);
		chk(48'(k), 48'(ok));
		if (ok)
		begin
			u_m.wbyte(c, ks[2]);
			u_m.wbyte(w[15:8], ks[1]);
			u_m.wbyte(w[7:0], ks[0]);
			chk(48'(ks), 48'h7);
		end
		u_m.stop();
		repeat (8) @(negedge core_clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_cal();
		int n;
		n = 0;
		wr(ADR, {qdrsc_pkg::OP_CODE_LOAD, 4'h8}, 16'hFFF0, 1'b1);
		chk(chan_code, 48'h0);
		while (cal_busy !== 1'b0 && n < 2 * CAL)
		begin
			@(negedge core_clk);
			n++;
		end
		chk(48'(n < CAL), 48'h1);
		$display("t_cal done");
	endtask

	task automatic t_pend();
		wr(ADR, {qdrsc_pkg::OP_CODE, 4'h1}, 16'hABC5, 1'b1);
		chk(chan_code, 48'h0);
		wr(ADR, {qdrsc_pkg::OP_LOAD, 4'h1}, 16'h0000, 1'b1);
		chk(chan_code, {24'h0, 12'hABC, 12'h0});
		wr(ADR, {qdrsc_pkg::OP_CODE_LOAD, 4'h8}, 16'h5550, 1'b1);
		chk(chan_code, {4{12'h555}});
		wr(ADR, {qdrsc_pkg::OP_CODE, 4'h0}, 16'h1230, 1'b1);
		wr(ADR, {qdrsc_pkg::OP_LOAD, 4'h8}, 16'h0000, 1'b1);
		chk(chan_code, {{3{12'h555}}, 12'h123});
		$display("t_pend done");
	endtask

	task automatic t_pd();
		wr(ADR, {qdrsc_pkg::OP_POWER, 4'h0}, 16'h000F, 1'b1);
		chk(48'(chan_pd), 48'hF);
		wr(ADR, {qdrsc_pkg::OP_CODE, 4'h2}, 16'h7770, 1'b1);
		wr(ADR, {qdrsc_pkg::OP_LOAD, 4'h2}, 16'h0000, 1'b1);
		chk(chan_code, {12'h555, 12'h777, 12'h555, 12'h123});
		wr(ADR, {qdrsc_pkg::OP_POWER, 4'h0}, 16'h0000, 1'b1);
		chk({chan_code[43:0], chan_pd}, {8'h55, 12'h777, 12'h555, 12'h123, 4'h0});
		$display("t_pd done");
	endtask

	task automatic t_ref();
		logic [1:0] rs [3];
		rs = '{qdrsc_pkg::REF_2V048, qdrsc_pkg::REF_2V500, qdrsc_pkg::REF_4V096};
		for (int i = 0; i < 3; i++)
		begin
			wr(ADR, {qdrsc_pkg::OP_REF, 4'h0}, {14'h0, rs[i]}, 1'b1);
			chk(48'(ref_sel), 48'(rs[i]));
		end
		wr(ADR, {qdrsc_pkg::OP_RESET, 4'h0}, 16'h0000, 1'b1);
		chk({chan_code[45:0], ref_sel}, {46'h0, qdrsc_pkg::REF_EXT});
		$display("t_ref done");
	endtask

	task automatic t_addr();
		logic k;
		wr(ADR1, {qdrsc_pkg::OP_CODE_LOAD, 4'h0}, 16'h9990, 1'b0);
		wr(qdrsc_pkg::BCAST_ADDR, {qdrsc_pkg::OP_CODE_LOAD, 4'h3}, 16'h4440, 1'b1);
		chk(chan_code, {12'h444, 36'h0});
		u_m.start();
		u_m.wbyte({qdrsc_pkg::BCAST_ADDR, 1'b1}, k);
		chk(48'(k), 48'h0);
		u_m.stop();
		addr_sel = 2'h1;
		repeat (4) @(negedge core_clk);
		wr(ADR1, {qdrsc_pkg::OP_CODE_LOAD, 4'h0}, 16'h2220, 1'b1);
		chk(chan_code, {12'h444, 24'h0, 12'h222});
		$display("t_addr done");
	endtask

	task automatic t_read();
		logic [2:0] ks;
		logic [7:0] d0;
		logic [7:0] d1;
		u_m.start();
		u_m.wbyte({ADR1, 1'b0}, ks[2]);
		u_m.wbyte({qdrsc_pkg::OP_CODE, 4'h3}, ks[1]);
		u_m.start();
		u_m.wbyte({ADR1, 1'b1}, ks[0]);
		u_m.rbyte(1'b0, d0);
		u_m.rbyte(1'b1, d1);
		u_m.stop();
		chk(48'({ks, d0, d1}), 48'h74440);
		chk(48'({sda_oe_n, sda_out}), 48'h2);
		u_m.start();
		u_m.wbyte({ADR1, 1'b0}, ks[2]);
		u_m.wbyte({qdrsc_pkg::OP_CODE_LOAD, 4'h3}, ks[1]);
		u_m.wbyte(8'h99, ks[0]);
		u_m.stop();
		chk(chan_code, {12'h444, 24'h0, 12'h222});
		wr(ADR1, {qdrsc_pkg::OP_CLEAR, 4'h0}, 16'h0000, 1'b1);
		wr(ADR1, {qdrsc_pkg::OP_LOAD, 4'h8}, 16'h0000, 1'b1);
		chk(chan_code, 48'h0);
		$display("t_read done");
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		chk(chan_code, 48'h0);
		chk(48'({chan_pd, ref_sel, cal_busy, sda_oe_n, sda_out}), 48'h006);
		t_cal();
		t_pend();
		t_pd();
		t_ref();
		t_addr();
		t_read();
		test_done();
	end
endmodule
